//--- verilog/shrb_pkg.sv
`default_nettype none
package shrb_pkg;
  // register byte offsets (most significant byte of each word)
  localparam logic [7:0] OFS_EXT_WRITE_ADDRESS   = 8'h02;
  localparam logic [7:0] OFS_EXT_WRITE_DATA_HIGH = 8'h04;
  localparam logic [7:0] OFS_EXT_WRITE_DATA_LOW  = 8'h06;
  localparam logic [7:0] OFS_EXT_WRITE_CONTROL   = 8'h08;
  localparam logic [7:0] OFS_EXT_READ_ADDRESS    = 8'h0a;
  localparam logic [7:0] OFS_EXT_READ_CONTROL    = 8'h0c;
  localparam logic [7:0] OFS_EXT_READ_DATA_HIGH  = 8'h0e;
  localparam logic [7:0] OFS_EXT_READ_DATA_LOW   = 8'h10;
  localparam logic [7:0] OFS_ACTION_CONTROL      = 8'h1e;
  localparam logic [7:0] OFS_ANGLE_OUTPUT        = 8'h20;
  localparam logic [7:0] OFS_DEVICE_STATE        = 8'h22;
  localparam logic [7:0] OFS_FAULT_LATCH         = 8'h24;
  localparam logic [7:0] OFS_CAUTION_LATCH       = 8'h26;
  // field positions
  localparam int BIT_DONE        = 0;
  localparam int BIT_IN_PROGRESS = 8;
  localparam int BIT_TRIGGER     = 15;
  localparam int BIT_FAULT_CLEAR = 8;
  localparam int BIT_CAUTION_CLR = 9;
  localparam int BIT_STATE_CLEAR = 10;
  localparam int BIT_SER_OVR     = 11;
  localparam int BIT_SEL_LSB     = 12;
  localparam int BIT_PARITY      = 12;
  localparam int BIT_LOW_SUPPLY  = 13;
  localparam int BIT_ANY_FAULT   = 14;
  localparam int BIT_ANGLE_VALID = 0;
  localparam int BIT_BOOT_RUN    = 1;
  localparam int BIT_HALL_RUN    = 2;
  localparam int BIT_LOGIC_RUN   = 3;
  localparam int BIT_BOOT_DONE   = 4;
  localparam int BIT_ACTION_DONE = 5;
  localparam int BIT_RESET_FAULT = 0;
  localparam int BIT_ANALOG_LOW  = 2;
  localparam int BIT_DIGITAL_LOW = 3;
  localparam int BIT_OVERFLOW    = 2;
  localparam int BIT_EXEC_FAULT  = 7;
  // memory windows
  localparam logic [7:0] SHADOW_DISTANCE = 8'h40;
  localparam logic [7:0] NVM_FIRST       = 8'h00;
  localparam logic [7:0] NVM_LAST        = 8'h1f;
  localparam logic [7:0] SHADOW_FIRST    = 8'h40;
  localparam logic [7:0] SHADOW_LAST     = 8'h5f;
  // action keys
  localparam logic [7:0] KEY_TURNS  = 8'h46;
  localparam logic [7:0] KEY_HARD   = 8'h5a;
  localparam logic [7:0] KEY_RELOAD = 8'ha5;
  localparam logic [7:0] KEY_TEST   = 8'hb9;
  // action select codes
  localparam logic [3:0] SEL_NONE      = 4'h0;
  localparam logic [3:0] SEL_MARGIN_LO = 4'h1;
  localparam logic [3:0] SEL_MARGIN_HI = 4'h2;
  localparam logic [3:0] SEL_TURNS_LD  = 4'h3;
  localparam logic [3:0] SEL_TURNS_RST = 4'h4;
  localparam logic [3:0] SEL_RELOAD    = 4'h5;
  localparam logic [3:0] SEL_HARD      = 4'h7;
  localparam logic [3:0] SEL_HALL_TEST = 4'h9;
  localparam logic [3:0] SEL_LOGIC_TST = 4'ha;
  localparam logic [3:0] SEL_BOTH_TEST = 4'hb;
  localparam logic [3:0] SEL_PWM_RESMP = 4'hd;
  localparam logic [3:0] SEL_PWM_CLEAR = 4'he;
  localparam logic [3:0] SEL_PWM_BOTH  = 4'hf;
  // timing
  localparam int CLOCK_HZ        = 40_000_000;
  localparam int NVM_WRITE_MS    = 24;
  localparam int NVM_READ_US     = 2;
  localparam int NVM_WRITE_CYC   = CLOCK_HZ / 1000 * NVM_WRITE_MS;
  localparam int NVM_READ_CYC    = CLOCK_HZ / 1_000_000 * NVM_READ_US;
  localparam logic [15:0] RESET_WORD = 16'h0000;
endpackage : shrb_pkg
`default_nettype wire

//--- verilog/shrb_bank.sv
// Behaviour
// - shadow addresses sit 0x40 above nonvolatile
// - 8-bit write address, unlocked writes only
// - write data from two 16-bit halves
// - write trigger starts write, flags progress
// - 8-bit read address, nonvolatile read slower
// - read address may change after logic test/reload
// - read trigger starts read, flags progress
// - read result valid once read-done set
// - key after select; key reads zero
// - margin codes need unlock
// - turns load/reset after turns key
// - reload and hard reset need unlock
// - self-tests start after test key
// - PWM resample and fatal clear codes
// - action done cleared on trigger, set after
// - error/warning clear only read bits
// - status clear drops action/boot done
// - override forces SPI on serial output
// - angle 12 bits, fault flag bit 14
// - odd parity bit 12
// - errors latch; undervoltage re-sets
// - reset error on power-on or hard reset
// - locked write ends with execute fault
// - trigger while busy sets overflow
`timescale 1ns/100ps
`default_nettype none
module shrb_bank #(
  parameter int NVM_WRITE_CYCLES = shrb_pkg::NVM_WRITE_CYC,
  parameter int NVM_READ_CYCLES  = shrb_pkg::NVM_READ_CYC
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        unlocked,
  input  wire logic [11:0] pll_angle,
  input  wire logic        pll_locked,
  input  wire logic        analog_low_supply,
  input  wire logic        digital_low_supply,
  input  wire logic [15:0] fault_events,
  input  wire logic [15:0] fault_mask,
  input  wire logic        caution_events_other,
  input  wire logic        caution_mask_any,
  output logic      [7:0]  mem_addr,
  output logic      [31:0] mem_wdata,
  output logic             mem_write_stb,
  output logic             mem_read_stb,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_write_fail,
  output logic             margin_low,
  output logic             margin_high,
  output logic             turns_load_stb,
  output logic             turns_reset_stb,
  output logic             reload_stb,
  output logic             hard_reset_stb,
  output logic             hall_test_stb,
  output logic             logic_test_stb,
  output logic             pwm_resample_stb,
  output logic             pwm_fatal_clear_stb,
  input  wire logic        action_busy,
  input  wire logic        boot_running,
  input  wire logic        boot_finished,
  input  wire logic        hall_test_running,
  input  wire logic        logic_test_running,
  input  wire logic        hard_reset_seen,
  input  wire logic        spi_out,
  input  wire logic        alt_out,
  output logic             serial_out
);

  typedef enum logic [2:0] {
    SHRB_IDLE  = 3'b001,
    SHRB_WRITE = 3'b010,
    SHRB_READ  = 3'b100
  } shrb_state_e;

  function automatic logic addr_valid(input logic [7:0] a);
    addr_valid = (a <= shrb_pkg::NVM_LAST) ||
                 (a >= shrb_pkg::SHADOW_FIRST && a <= shrb_pkg::SHADOW_LAST);
  endfunction : addr_valid

  function automatic logic is_nvm(input logic [7:0] a);
    is_nvm = a < shrb_pkg::SHADOW_DISTANCE;
  endfunction : is_nvm

  shrb_state_e state_r;
  logic [7:0]  wr_addr_r;
  logic [15:0] wr_high_r;
  logic [15:0] wr_low_r;
  logic [7:0]  rd_addr_r;
  logic [31:0] rd_data_r;
  logic        wr_done_r;
  logic        rd_done_r;
  logic [24:0] wait_r;
  logic [3:0]  sel_r;
  logic        ser_ovr_r;
  logic        act_done_r;
  logic        act_pending_r;
  logic        boot_done_r;
  logic [15:0] fault_r;
  logic [15:0] fault_seen_r;
  logic [15:0] caution_r;
  logic [15:0] caution_seen_r;
  logic        first_r;
  logic        act_busy_q;

  wire wr_ctl  = reg_write && reg_addr == shrb_pkg::OFS_EXT_WRITE_CONTROL;
  wire rd_ctl  = reg_write && reg_addr == shrb_pkg::OFS_EXT_READ_CONTROL;
  wire act_wr  = reg_write && reg_addr == shrb_pkg::OFS_ACTION_CONTROL;
  wire wr_trig = wr_ctl && reg_wdata[shrb_pkg::BIT_TRIGGER];
  wire rd_trig = rd_ctl && reg_wdata[shrb_pkg::BIT_TRIGGER];
  wire idle    = state_r == SHRB_IDLE;
  wire [7:0] key = reg_wdata[7:0];
  wire [3:0] sel_in = reg_wdata[shrb_pkg::BIT_SEL_LSB +: 4];

  wire wr_ok = unlocked && addr_valid(wr_addr_r);
  wire rd_ok = addr_valid(rd_addr_r);
  wire wait_end = wait_r == '0;
  wire wr_start = wr_trig && idle;
  wire rd_start = rd_trig && idle && !wr_trig;
  wire exec_fault = (wr_start && !wr_ok) || (rd_start && !rd_ok) ||
                    (state_r == SHRB_WRITE && wait_end && mem_write_fail);
  wire overflow = (wr_trig || rd_trig) && (!idle || (wr_trig && rd_trig));

  wire key_written = act_wr && key != 8'h00;
  wire key_turns   = key_written && key == shrb_pkg::KEY_TURNS;
  wire key_reload  = key_written && key == shrb_pkg::KEY_RELOAD;
  wire key_hard    = key_written && key == shrb_pkg::KEY_HARD;
  wire key_test    = key_written && key == shrb_pkg::KEY_TEST;
  wire go_load  = key_turns && sel_r == shrb_pkg::SEL_TURNS_LD;
  wire go_trst  = key_turns && sel_r == shrb_pkg::SEL_TURNS_RST;
  wire go_rel   = key_reload && sel_r == shrb_pkg::SEL_RELOAD && unlocked;
  wire go_hard  = key_hard && sel_r == shrb_pkg::SEL_HARD && unlocked;
  wire go_hall  = key_test && (sel_r == shrb_pkg::SEL_HALL_TEST ||
                               sel_r == shrb_pkg::SEL_BOTH_TEST);
  wire go_logic = key_test && (sel_r == shrb_pkg::SEL_LOGIC_TST ||
                               sel_r == shrb_pkg::SEL_BOTH_TEST);
  wire sel_new  = act_wr && key == 8'h00;
  wire go_resmp = sel_new && (sel_in == shrb_pkg::SEL_PWM_RESMP ||
                              sel_in == shrb_pkg::SEL_PWM_BOTH);
  wire go_fclr  = sel_new && (sel_in == shrb_pkg::SEL_PWM_CLEAR ||
                              sel_in == shrb_pkg::SEL_PWM_BOTH);
  wire go_keyed = go_load || go_trst || go_rel || go_hard || go_hall || go_logic;
  wire act_trig = go_keyed || go_resmp || go_fclr;
  wire act_end  = act_pending_r && !act_busy_q && !action_busy;

  wire rd_fault   = reg_read && reg_addr == shrb_pkg::OFS_FAULT_LATCH;
  wire rd_caution = reg_read && reg_addr == shrb_pkg::OFS_CAUTION_LATCH;
  wire clr_fault  = act_wr && reg_wdata[shrb_pkg::BIT_FAULT_CLEAR];
  wire clr_caut   = act_wr && reg_wdata[shrb_pkg::BIT_CAUTION_CLR];
  wire clr_state  = act_wr && reg_wdata[shrb_pkg::BIT_STATE_CLEAR];

  logic [15:0] fault_set;
  always_comb begin
    fault_set = fault_events;
    fault_set[shrb_pkg::BIT_ANALOG_LOW]  = analog_low_supply;
    fault_set[shrb_pkg::BIT_DIGITAL_LOW] = digital_low_supply;
    fault_set[shrb_pkg::BIT_RESET_FAULT] = first_r || hard_reset_seen;
  end
  logic [15:0] caution_set;
  always_comb begin
    caution_set = '0;
    caution_set[shrb_pkg::BIT_OVERFLOW]   = overflow;
    caution_set[shrb_pkg::BIT_EXEC_FAULT] = exec_fault;
    caution_set[1] = caution_events_other;
  end
  wire [15:0] fault_clr   = clr_fault ? fault_seen_r : 16'h0000;
  wire [15:0] caution_clr = clr_caut ? caution_seen_r : 16'h0000;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_addr_r <= '0;
      wr_high_r <= '0;
      wr_low_r  <= '0;
      ser_ovr_r <= 1'b0;
    end else if (reg_write) begin
      if (reg_addr == shrb_pkg::OFS_EXT_WRITE_ADDRESS) wr_addr_r <= reg_wdata[7:0];
      if (reg_addr == shrb_pkg::OFS_EXT_WRITE_DATA_HIGH) wr_high_r <= reg_wdata;
      if (reg_addr == shrb_pkg::OFS_EXT_WRITE_DATA_LOW) wr_low_r <= reg_wdata;
      if (act_wr && key == 8'h00) ser_ovr_r <= reg_wdata[shrb_pkg::BIT_SER_OVR];
    end
  end

  // read address returns to zero after logic test or reload
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_addr_r <= '0;
    end else if (go_logic || go_rel) begin
      rd_addr_r <= '0;
    end else if (reg_write && reg_addr == shrb_pkg::OFS_EXT_READ_ADDRESS) begin
      rd_addr_r <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= SHRB_IDLE;
      wr_done_r <= 1'b0;
      rd_done_r <= 1'b0;
      wait_r    <= '0;
      rd_data_r <= '0;
    end else begin
      unique case (state_r)
        SHRB_IDLE: begin
          if (wr_start) begin
            wr_done_r <= !wr_ok;
            state_r   <= wr_ok ? SHRB_WRITE : SHRB_IDLE;
            wait_r    <= is_nvm(wr_addr_r) ? 25'(NVM_WRITE_CYCLES - 1) : '0;
          end else if (rd_start) begin
            rd_done_r <= !rd_ok;
            state_r   <= rd_ok ? SHRB_READ : SHRB_IDLE;
            wait_r    <= is_nvm(rd_addr_r) ? 25'(NVM_READ_CYCLES - 1) : '0;
          end
        end
        SHRB_WRITE: begin
          if (wait_end) begin
            wr_done_r <= 1'b1;
            state_r   <= SHRB_IDLE;
          end else begin
            wait_r <= wait_r - 25'd1;
          end
        end
        SHRB_READ: begin
          if (wait_end) begin
            rd_data_r <= mem_rdata;
            rd_done_r <= 1'b1;
            state_r   <= SHRB_IDLE;
          end else begin
            wait_r <= wait_r - 25'd1;
          end
        end
        default: state_r <= SHRB_IDLE;
      endcase
    end
  end

  assign mem_addr      = state_r == SHRB_READ ? rd_addr_r : wr_addr_r;
  assign mem_wdata     = {wr_high_r, wr_low_r};
  assign mem_write_stb = state_r == SHRB_WRITE && wait_end && !mem_write_fail;
  assign mem_read_stb  = state_r == SHRB_READ && wait_end;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sel_r         <= shrb_pkg::SEL_NONE;
      act_done_r    <= 1'b0;
      act_pending_r <= 1'b0;
    end else begin
      if (act_trig) begin
        act_done_r    <= 1'b0;
        act_pending_r <= 1'b1;
      end else if (act_end) begin
        act_done_r    <= 1'b1;
        act_pending_r <= 1'b0;
        sel_r         <= shrb_pkg::SEL_NONE;
      end else if (clr_state) begin
        act_done_r <= 1'b0;
      end
      if (sel_new && !go_resmp && !go_fclr) begin
        sel_r <= ((sel_in == shrb_pkg::SEL_MARGIN_LO || sel_in == shrb_pkg::SEL_MARGIN_HI)
                  && !unlocked) ? shrb_pkg::SEL_NONE : sel_in;
      end
    end
  end

  // one cycle delay so done trails the strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      act_busy_q <= 1'b0;
    end else begin
      act_busy_q <= act_trig;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      boot_done_r <= 1'b0;
    end else if (boot_finished) begin
      boot_done_r <= 1'b1;
    end else if (clr_state) begin
      boot_done_r <= 1'b0;
    end
  end

  assign margin_low          = sel_r == shrb_pkg::SEL_MARGIN_LO;
  assign margin_high         = sel_r == shrb_pkg::SEL_MARGIN_HI;
  assign turns_load_stb      = go_load;
  assign turns_reset_stb     = go_trst;
  assign reload_stb          = go_rel;
  assign hard_reset_stb      = go_hard;
  assign hall_test_stb       = go_hall;
  assign logic_test_stb      = go_logic;
  assign pwm_resample_stb    = go_resmp;
  assign pwm_fatal_clear_stb = go_fclr;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      first_r      <= 1'b1;
      fault_r      <= '0;
      fault_seen_r <= '0;
    end else begin
      first_r      <= 1'b0;
      fault_r      <= (fault_r & ~fault_clr) | fault_set;
      fault_seen_r <= rd_fault ? fault_r : (fault_seen_r & ~fault_clr);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      caution_r      <= '0;
      caution_seen_r <= '0;
    end else begin
      caution_r      <= (caution_r & ~caution_clr) | caution_set;
      caution_seen_r <= rd_caution ? caution_r : (caution_seen_r & ~caution_clr);
    end
  end

  wire any_fault = |(fault_r & ~fault_mask) || (|caution_r && !caution_mask_any);
  wire [15:0] angle_raw = {1'b0, any_fault, analog_low_supply || digital_low_supply,
                           1'b0, pll_angle};
  wire [15:0] angle_word = angle_raw | {3'b000, ~^angle_raw, 12'h000};
  wire [15:0] state_word = {10'h000, act_done_r, boot_done_r, logic_test_running,
                            hall_test_running, boot_running, pll_locked};

  always_comb begin
    unique case (reg_addr)
      shrb_pkg::OFS_EXT_WRITE_ADDRESS:   reg_rdata = {8'h00, wr_addr_r};
      shrb_pkg::OFS_EXT_WRITE_DATA_HIGH: reg_rdata = wr_high_r;
      shrb_pkg::OFS_EXT_WRITE_DATA_LOW:  reg_rdata = wr_low_r;
      shrb_pkg::OFS_EXT_WRITE_CONTROL:
        reg_rdata = {7'h00, state_r == SHRB_WRITE, 7'h00, wr_done_r};
      shrb_pkg::OFS_EXT_READ_ADDRESS:    reg_rdata = {8'h00, rd_addr_r};
      shrb_pkg::OFS_EXT_READ_CONTROL:
        reg_rdata = {7'h00, state_r == SHRB_READ, 7'h00, rd_done_r};
      shrb_pkg::OFS_EXT_READ_DATA_HIGH:  reg_rdata = rd_data_r[31:16];
      shrb_pkg::OFS_EXT_READ_DATA_LOW:   reg_rdata = rd_data_r[15:0];
      shrb_pkg::OFS_ACTION_CONTROL:      reg_rdata = {sel_r, ser_ovr_r, 11'h000};
      shrb_pkg::OFS_ANGLE_OUTPUT:        reg_rdata = angle_word;
      shrb_pkg::OFS_DEVICE_STATE:        reg_rdata = state_word;
      shrb_pkg::OFS_FAULT_LATCH:         reg_rdata = fault_r;
      shrb_pkg::OFS_CAUTION_LATCH:       reg_rdata = caution_r;
      default:                           reg_rdata = shrb_pkg::RESET_WORD;
    endcase
  end

  assign serial_out = ser_ovr_r ? spi_out : alt_out;

endmodule : shrb_bank
`default_nettype wire

//--- dv/shrb_props.sv
`timescale 1ns/100ps
`default_nettype none
module shrb_props (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        reg_write,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        unlocked,
  input wire logic        spi_out,
  input wire logic        serial_out,
  input wire logic        mem_write_stb,
  input wire logic        margin_low,
  input wire logic        turns_load_stb,
  input wire logic        reload_stb,
  input wire logic        hard_reset_stb,
  input wire logic        hall_test_stb,
  input wire logic        pwm_fatal_clear_stb
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire logic       key_wr = reg_write && reg_addr == shrb_pkg::OFS_ACTION_CONTROL;
  wire logic [7:0] key    = reg_wdata[7:0];
  a_wtrig_reads_zero: assert property (reg_addr == 8'h08 |-> !reg_rdata[15])
    else $error("write trigger read back as one");
  a_rtrig_reads_zero: assert property (reg_addr == 8'h0c |-> !reg_rdata[15])
    else $error("read trigger read back as one");
  a_key_reads_zero: assert property (reg_addr == 8'h1e |-> reg_rdata[10:0] == 11'h000)
    else $error("key or clear strobes read back nonzero");
  a_angle_odd_parity: assert property (reg_addr == 8'h20 |-> ^reg_rdata)
    else $error("angle word has even parity");
  a_override_spi: assert property (reg_addr == 8'h1e && reg_rdata[11] |-> serial_out == spi_out)
    else $error("serial output not spi under override");
  a_turns_keyed: assert property (turns_load_stb |-> key_wr && key == 8'h46)
    else $error("turns load without turns key");
  a_hard_unlocked: assert property (hard_reset_stb |-> unlocked && key_wr && key == 8'h5a)
    else $error("hard reset without key or unlock");
  a_reload_unlocked: assert property (reload_stb |-> unlocked && key_wr && key == 8'ha5)
    else $error("reload without key or unlock");
  a_hall_test_keyed: assert property (hall_test_stb |-> key_wr && key == 8'hb9)
    else $error("hall test without test key");
  a_pwm_on_write: assert property (pwm_fatal_clear_stb |-> key_wr)
    else $error("pwm clear without control write");
  a_margin_unlocked: assert property ($rose(margin_low) |-> $past(unlocked))
    else $error("margin enabled while locked");
  c_mem_write: cover property (mem_write_stb);
  c_hard_reset: cover property (hard_reset_stb);
  c_margin: cover property (margin_low);
endmodule : shrb_props
bind shrb_bank shrb_props u_props (.clock(clock), .reset_n(reset_n), .reg_write(reg_write),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .unlocked(unlocked),
  .spi_out(spi_out), .serial_out(serial_out), .mem_write_stb(mem_write_stb),
  .margin_low(margin_low), .turns_load_stb(turns_load_stb), .reload_stb(reload_stb),
  .hard_reset_stb(hard_reset_stb), .hall_test_stb(hall_test_stb),
  .pwm_fatal_clear_stb(pwm_fatal_clear_stb));
`default_nettype wire

//--- dv/shrb_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module shrb_mem_model (
  input  wire logic        clock,
  input  wire logic [7:0]  mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic        mem_write_stb,
  input  wire logic        mem_read_stb,
  output logic      [31:0] mem_rdata
);
  logic [31:0] cells [256];
  logic [31:0] last_r = 32'h0000_0000;
  initial begin
    for (int i = 0; i < 256; i++) cells[i] = {24'h5a5a5a, i[7:0]};
  end
  always @(posedge clock) begin
    if (mem_write_stb) cells[mem_addr] <= mem_wdata;
    if (mem_read_stb) last_r <= cells[mem_addr];
  end
  // outside a read the bus shows the inverse of the last answer
  assign mem_rdata = mem_read_stb ? cells[mem_addr] : ~last_r;
endmodule : shrb_mem_model
`default_nettype wire

//--- dv/serial_host_register_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none
module serial_host_register_bank_tb;
  localparam logic [3:0] SELS [10] = '{4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hd, 4'he, 4'hf};
  localparam logic [7:0] KEYS [10] = '{8'h46, 8'h46, 8'ha5, 8'h5a, 8'hb9, 8'hb9, 8'hb9, 8'h00,
                                       8'h00, 8'h00};
  localparam logic [7:0] MASKS [10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h0c, 8'h02,
                                        8'h01, 8'h03};
  logic clock, reset_n = 0, reg_write = 0, reg_read = 0, unlocked = 1, pll_locked = 1;
  logic analog_low_supply = 0, digital_low_supply = 0, caution_events_other = 0;
  logic caution_mask_any = 0, mem_write_fail = 0, action_busy = 0, boot_running = 0;
  logic boot_finished = 0, hall_test_running = 0, logic_test_running = 0, hard_reset_seen = 0;
  logic spi_out = 0, alt_out = 1;
  logic [7:0]  reg_addr = 0, seen = 0;
  logic [11:0] pll_angle = 12'h5a3;
  logic [15:0] reg_wdata = 0, fault_events = 0, fault_mask = 0;
  wire logic [15:0] reg_rdata;
  wire logic [7:0]  mem_addr;
  wire logic [31:0] mem_wdata, mem_rdata;
  wire logic mem_write_stb, mem_read_stb, margin_low, margin_high, serial_out;
  wire logic turns_load_stb, turns_reset_stb, reload_stb, hard_reset_stb, hall_test_stb;
  wire logic logic_test_stb, pwm_resample_stb, pwm_fatal_clear_stb;
  int errors = 0, comparisons = 0;
  shrb_bank #(.NVM_WRITE_CYCLES(8), .NVM_READ_CYCLES(4)) u_dut (.clock, .reset_n, .reg_write,
    .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .unlocked, .pll_angle, .pll_locked,
    .analog_low_supply, .digital_low_supply, .fault_events, .fault_mask, .caution_events_other,
    .caution_mask_any, .mem_addr, .mem_wdata, .mem_write_stb, .mem_read_stb, .mem_rdata,
    .mem_write_fail, .margin_low, .margin_high, .turns_load_stb, .turns_reset_stb, .reload_stb,
    .hard_reset_stb, .hall_test_stb, .logic_test_stb, .pwm_resample_stb, .pwm_fatal_clear_stb,
    .action_busy, .boot_running, .boot_finished, .hall_test_running, .logic_test_running,
    .hard_reset_seen, .spi_out, .alt_out, .serial_out);
  shrb_mem_model u_mem (.clock, .mem_addr, .mem_wdata, .mem_write_stb, .mem_read_stb,
    .mem_rdata);
  always @(posedge clock) seen = seen | {turns_load_stb, turns_reset_stb, reload_stb,
    hard_reset_stb, hall_test_stb, logic_test_stb, pwm_resample_stb, pwm_fatal_clear_stb};
  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1;
    @(negedge clock);
    reg_write = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1;
    #5 d = reg_rdata;
    @(negedge clock);
    reg_read = 0;
  endtask : rd
  task automatic rc(input string n, input logic [7:0] a, input logic [15:0] m, e);
    logic [15:0] v;
    rd(a, v);
    chk(n, e, v & m);
  endtask : rc
  task automatic poll(input logic [7:0] a, input int lim);
    logic [15:0] v;
    v = 0;
    for (int i = 0; i < lim && v[0] !== 1'b1; i++) rd(a, v);
    chk("done bit", 1, v[0]);
  endtask : poll
  task automatic t_shadow();
    wr(8'h02, 16'h0045);
    wr(8'h04, 16'h1234);
    wr(8'h06, 16'hbeef);
    wr(8'h08, 16'h8000);
    poll(8'h08, 6);
    chk("shadow cell", 32'h1234beef, u_mem.cells[8'h45]);
    wr(8'h0a, 16'h0045);
    wr(8'h0c, 16'h8000);
    poll(8'h0c, 6);
    rc("read high", 8'h0e, 16'hffff, 16'h1234);
    rc("read low", 8'h10, 16'hffff, 16'hbeef);
  endtask : t_shadow
  task automatic t_nvm_busy();
    wr(8'h02, 16'h001f);
    wr(8'h08, 16'h8000);
    rc("write busy", 8'h08, 16'h0101, 16'h0100);
    wr(8'h08, 16'h8000);
    poll(8'h08, 12);
    rc("overflow", 8'h26, 16'h0004, 16'h0004);
    chk("nvm cell", 32'h1234beef, u_mem.cells[8'h1f]);
    wr(8'h0a, 16'h001f);
    wr(8'h0c, 16'h8000);
    rc("read busy", 8'h0c, 16'h0101, 16'h0100);
    poll(8'h0c, 8);
    rc("nvm read", 8'h10, 16'hffff, 16'hbeef);
  endtask : t_nvm_busy
  task automatic t_locked();
    unlocked = 0;
    wr(8'h02, 16'h0046);
    wr(8'h08, 16'h8000);
    poll(8'h08, 3);
    rc("exec fault", 8'h26, 16'h0080, 16'h0080);
    chk("locked cell", {24'h5a5a5a, 8'h46}, u_mem.cells[8'h46]);
    seen = 0;
    wr(8'h1e, 16'h7000);
    wr(8'h1e, 16'h705a);
    chk("locked hard reset", 0, seen);
    wr(8'h1e, 16'h2000);
    chk("locked margin", 0, margin_high);
    wr(8'h1e, 16'h0000);
    unlocked = 1;
  endtask : t_locked
  task automatic t_actions();
    for (int i = 0; i < 10; i++) begin
      action_busy = 1;
      seen = 0;
      wr(8'h1e, {SELS[i], 12'h000});
      wr(8'h1e, {SELS[i], 4'h0, KEYS[i]});
      rc("action done low", 8'h22, 16'h0020, 16'h0000);
      action_busy = 0;
      repeat (4) @(negedge clock);
      chk("action strobes", MASKS[i], seen);
      rc("action done", 8'h22, 16'h0020, 16'h0020);
      rc("select cleared", 8'h1e, 16'hf000, 16'h0000);
    end
    rc("read address", 8'h0a, 16'h00ff, 16'h0000);
    boot_finished = 1;
    @(negedge clock);
    boot_finished = 0;
    rc("boot done", 8'h22, 16'h0010, 16'h0010);
    wr(8'h1e, 16'h0400);
    rc("state cleared", 8'h22, 16'h0030, 16'h0000);
    wr(8'h1e, 16'h1000);
    chk("margin low", 1, margin_low);
    wr(8'h1e, 16'h2000);
    chk("margin high", 1, margin_high);
    wr(8'h1e, 16'h0800);
    chk("override", spi_out, serial_out);
    wr(8'h1e, 16'h0000);
    chk("no override", alt_out, serial_out);
  endtask : t_actions
  task automatic t_faults();
    logic [15:0] v;
    rc("reset cause", 8'h24, 16'h0001, 16'h0001);
    fault_events = 16'h0020;
    @(negedge clock);
    fault_events = 0;
    rd(8'h20, v);
    chk("fault flag", 1, v[14]);
    chk("angle", 12'h5a3, v[11:0]);
    wr(8'h1e, 16'h0100);
    rc("unread kept", 8'h24, 16'h0021, 16'h0020);
    analog_low_supply = 1;
    rc("low supply", 8'h24, 16'h0004, 16'h0004);
    wr(8'h1e, 16'h0100);
    rc("low supply again", 8'h24, 16'h0004, 16'h0004);
    analog_low_supply = 0;
    rd(8'h26, v);
    wr(8'h1e, 16'h0300);
    rc("all cleared", 8'h24, 16'h0025, 16'h0000);
    rc("flag clear", 8'h20, 16'h4000, 16'h0000);
    hard_reset_seen = 1;
    @(negedge clock);
    hard_reset_seen = 0;
    rc("hard reset cause", 8'h24, 16'h0001, 16'h0001);
  endtask : t_faults
  task automatic complete_run();
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    #(25 * 4000);
    errors++;
    complete_run();
  end
  initial begin
    repeat (8) @(negedge clock);
    reset_n = 1;
    t_shadow();
    t_nvm_busy();
    t_locked();
    t_actions();
    t_faults();
    complete_run();
  end
endmodule : serial_host_register_bank_tb
`default_nettype wire
